// ==== cesf_flags.sv ====
// Sticky read-clear event flag bank.
module cesf_flags
	import cesf_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Events and clear
	input  wire logic [5:0] evt,
	input  wire logic       rd_clr,
	output logic      [5:0] flags_ff
);
	import cesf_pkg::*;

	// A set in the clearing cycle wins so the event is reported on the next read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= CESF_STATUS_RST[5:0];
		end else if (rd_clr) begin
			flags_ff <= evt;
		end else begin
			flags_ff <= flags_ff | evt;
		end
	end
endmodule : cesf_flags

// ==== cesf_pkg.sv ====
// Package with register map, field positions and reset values of the converter event status block.
package cesf_pkg;
	localparam logic [7:0] CESF_OFS_STATUS    = 8'h04;
	localparam logic [7:0] CESF_OFS_CONTROL   = 8'h00;
	localparam logic [7:0] CESF_OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] CESF_OFS_IRQ_EN    = 8'h24;
	localparam logic [7:0] CESF_OFS_IRQ_CLR   = 8'h28;
	localparam logic [3:0] CESF_STATUS_INDEX  = 4'h4;
	localparam logic [7:0] CESF_STATUS_RST    = 8'h02;
	localparam logic [7:0] CESF_CONTROL_RST   = 8'h00;
	localparam int         CESF_NUM_FLAGS     = 6;
	localparam int         CESF_BIT_RETRY     = 5;
	localparam int         CESF_BIT_CURRENT_LIMIT_FLAG      = 4;
	localparam int         CESF_BIT_THERMAL_WARNING_FLAG     = 3;
	localparam int         CESF_BIT_THERMAL_SHUTDOWN_FLAG     = 2;
	localparam int         CESF_BIT_UV        = 1;
	localparam int         CESF_BIT_OV        = 0;
	localparam int         CESF_CTL_RETRY_EN  = 0;
	localparam int         CESF_IRQ_READCLR   = 0;
	localparam logic [5:0] CESF_FLAGS_MASK    = 6'h3f;
	localparam logic [1:0] CESF_IRQ_RST       = 2'h0;
	typedef enum logic [1:0] {CESF_APB_IDLE, CESF_APB_SETUP, CESF_APB_ACCESS} cesf_apb_state_t;
endpackage : cesf_pkg

// ==== cesf_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous event inputs.
module cesf_sync
	import cesf_pkg::*;
#(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// The first stage is read only by the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : cesf_sync

// ==== cesf_top.sv ====
// APB slave holding the converter event status register, its retry control and interrupt logic.
//
// Operation
// - The status register sits at byte address 4h and resets to 2h.
// - Bits 7 and 6 are reserved, read zero, and software ignores them.
// - Bit 5 reports a retry-mode shutdown event since the last status read, reset 0.
// - Bit 4 reports a current limit event since the last status read, reset 0.
// - Bit 3 reports a thermal warning event since the last status read, reset 0.
// - Bit 2 reports a thermal shutdown event since the last status read, reset 0.
// - Bit 1 reports an output-too-low event since the last read and resets to 1.
// - Bit 0 reports an output-too-high event since the last status read, reset 0.
// - Flags are sticky and a status read clears them.
// - Retry shutdown events count only while the retry mode enable is set.
module cesf_top
	import cesf_pkg::*;
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Asynchronous events from the analog supervisors
	input  wire logic        retry_shutdown_evt,
	input  wire logic        current_limit_evt,
	input  wire logic        thermal_warning_evt,
	input  wire logic        thermal_shutdown_evt,
	input  wire logic        output_undervoltage_evt,
	input  wire logic        output_overvoltage_evt,
	// Control and interrupt
	output logic             retry_mode_enable,
	output logic             irq
);
	import cesf_pkg::*;

	logic [5:0]  evt_async;
	logic [5:0]  evt_sync;
	logic [5:0]  evt_rise;
	logic [5:0]  evt_prev_ff;
	logic [5:0]  evt_gated;
	logic [5:0]  flags;
	logic [7:0]  control_ff;
	logic [1:0]  irq_stat_ff;
	logic [1:0]  irq_en_ff;
	logic [1:0]  irq_set;
	logic        access;
	logic        wr;
	logic        rd;
	logic        status_rd;
	logic        mapped;
	logic [31:0] nxt_prdata;
	logic [5:0]  status_val;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	assign evt_async = {retry_shutdown_evt, current_limit_evt, thermal_warning_evt,
		thermal_shutdown_evt, output_undervoltage_evt, output_overvoltage_evt};

	cesf_sync #(.WIDTH(CESF_NUM_FLAGS)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (evt_async),
		.sync_out (evt_sync)
	);

	// Edge detection keeps a long-standing fault from re-setting a flag forever after a read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_prev_ff <= '0;
		end else begin
			evt_prev_ff <= evt_sync;
		end
	end

	assign evt_rise = evt_sync & ~evt_prev_ff;

	always_comb begin
		evt_gated = evt_rise;
		evt_gated[CESF_BIT_RETRY] = evt_rise[CESF_BIT_RETRY] & control_ff[CESF_CTL_RETRY_EN];
	end

	// APB decode; the slave always answers in the first access cycle.
	assign access    = psel & penable;
	assign wr        = access & pwrite;
	assign rd        = access & ~pwrite;
	assign pready    = 1'b1;
	assign status_rd = rd & hit(paddr, CESF_OFS_STATUS);
	assign mapped    = hit(paddr, CESF_OFS_STATUS) | hit(paddr, CESF_OFS_CONTROL) | hit(paddr, CESF_OFS_IRQ_STAT)
		| hit(paddr, CESF_OFS_IRQ_EN) | hit(paddr, CESF_OFS_IRQ_CLR);
	assign pslverr   = access & ~mapped;

	cesf_flags u_flags (
		.pclk     (pclk),
		.presetn  (presetn),
		.evt      (evt_gated),
		.rd_clr   (status_rd),
		.flags_ff (flags)
	);

	// Control register; only the retry enable bit is implemented.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_ff <= CESF_CONTROL_RST;
		end else if (wr && hit(paddr, CESF_OFS_CONTROL) && pstrb[0]) begin
			control_ff <= {7'h00, pwdata[CESF_CTL_RETRY_EN]};
		end
	end

	assign retry_mode_enable = control_ff[CESF_CTL_RETRY_EN];

	// Interrupt sources: bit 0 any new event, bit 1 unused reserve kept zero.
	assign irq_set = {1'b0, |evt_gated};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= CESF_IRQ_RST;
		end else if (wr && hit(paddr, CESF_OFS_IRQ_CLR) && pstrb[0]) begin
			irq_stat_ff <= (irq_stat_ff & ~pwdata[1:0]) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= CESF_IRQ_RST;
		end else if (wr && hit(paddr, CESF_OFS_IRQ_EN) && pstrb[0]) begin
			irq_en_ff <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// The snapshot includes events landing at the setup edge, else the clear would drop them unreported.
	assign status_val = status_rd ? evt_gated : (flags | evt_gated);

	// Status writes fall through with no effect.
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit(paddr, CESF_OFS_STATUS)) begin
			nxt_prdata = {26'h0, status_val};
		end else if (hit(paddr, CESF_OFS_CONTROL)) begin
			nxt_prdata = {24'h0, control_ff};
		end else if (hit(paddr, CESF_OFS_IRQ_STAT)) begin
			nxt_prdata = {30'h0, irq_stat_ff};
		end else if (hit(paddr, CESF_OFS_IRQ_EN)) begin
			nxt_prdata = {30'h0, irq_en_ff};
		end
	end

	// Read data is registered in the setup cycle so it is stable when the access completes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= nxt_prdata;
		end
	end
endmodule : cesf_top

// ==== cesf_top_chk.sv ====
// Checker for the APB side of the event status block.
module cesf_top_chk
	import cesf_pkg::*;
(
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Control
	input wire logic        retry_mode_enable
);
	logic ok_adr;
	logic ctl_wr;
	assign ok_adr = paddr inside {CESF_OFS_CONTROL, CESF_OFS_STATUS, CESF_OFS_IRQ_STAT, CESF_OFS_IRQ_EN,
		CESF_OFS_IRQ_CLR};
	assign ctl_wr = psel && penable && pwrite && paddr == CESF_OFS_CONTROL && pstrb[0];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd_setup;
		psel && !penable && !pwrite;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmap_err: assert property (s_access ##0 !ok_adr |-> pslverr) else $error("no pslverr");
	a_map_ok: assert property (s_access ##0 ok_adr |-> !pslverr) else $error("bad pslverr");
	a_rsvd_zero: assert property (s_rd_setup ##0 paddr == CESF_OFS_STATUS |=> prdata[31:6] == 26'h0)
		else $error("reserved bits set");
	a_unmap_rd: assert property (s_rd_setup ##0 !ok_adr |=> prdata == 32'h0) else $error("unmapped data");
	a_rdata_hold: assert property (not s_rd_setup |=> $stable(prdata)) else $error("prdata moved");
	a_ctl_write: assert property (ctl_wr |=> retry_mode_enable == $past(pwdata[0]))
		else $error("control not written");
	a_ctl_keep: assert property (!ctl_wr |=> $stable(retry_mode_enable)) else $error("control moved");
endmodule : cesf_top_chk

bind cesf_top cesf_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .retry_mode_enable(retry_mode_enable));

// ==== tb_top.sv ====
// Testbench for the converter event status block.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import cesf_pkg::*;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [5:0]  evt = 6'h00;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, retry_mode_enable, irq;
	int          n_errors = 0;
	int          check_count = 0;
	always #2.5 pclk = ~pclk;
	cesf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.retry_shutdown_evt(evt[5]), .current_limit_evt(evt[4]), .thermal_warning_evt(evt[3]),
		.thermal_shutdown_evt(evt[2]), .output_undervoltage_evt(evt[1]), .output_overvoltage_evt(evt[0]),
		.retry_mode_enable(retry_mode_enable), .irq(irq));
	task automatic wrap_up;
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	// The request is held until pready is seen high, for at most 16 cycles, so a slower slave is still served.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin
			n_errors++;
			wrap_up();
		end else begin
			rd = prdata;
			er = pslverr;
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic pulse(input logic [5:0] m);
		@(posedge pclk);
		evt <= m;
		@(posedge pclk);
		evt <= 6'h00;
		repeat (4) @(posedge pclk);
	endtask : pulse
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("status reset", 32'h2, rd);
		apb(1'h1, CESF_OFS_STATUS, 32'hff);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("status cleared", 32'h0, rd);
		for (int i = 0; i < 5; i++) begin
			pulse(6'h01 << i);
			apb(1'h0, CESF_OFS_STATUS, 32'h0);
			chk("event flag", 32'h1 << i, rd);
		end
		pulse(6'h20);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("retry off", 32'h0, rd);
		apb(1'h1, CESF_OFS_CONTROL, 32'h1);
		@(posedge pclk);
		chk("retry enable", 32'h1, {31'h0, retry_mode_enable});
		pulse(6'h20);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("retry flag", 32'h20, rd);
		@(posedge pclk);
		evt <= 6'h08;
		repeat (5) @(posedge pclk);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("held first", 32'h8, rd);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("held event", 32'h0, rd);
		@(posedge pclk);
		evt <= 6'h10;
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("race read", 32'h0, rd);
		apb(1'h0, CESF_OFS_STATUS, 32'h0);
		chk("race kept", 32'h10, rd);
		apb(1'h1, CESF_OFS_IRQ_CLR, 32'h1);
		apb(1'h1, CESF_OFS_IRQ_EN, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq idle", 32'h0, {31'h0, irq});
		pulse(6'h01);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'h1, CESF_OFS_IRQ_CLR, 32'h1);
		apb(1'h1, CESF_OFS_IRQ_EN, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		pulse(6'h01);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'h0, CESF_OFS_IRQ_STAT, 32'h0);
		chk("irq status", 32'h1, rd);
		apb(1'h0, 8'h3c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		wrap_up();
	end
endmodule : tb_top
